// ==== common/sep_pkg.sv ====
// Operation
// RULE_01: Byte write carries one data byte, acknowledged
// RULE_02: Protected data byte gets no acknowledge, unchanged
// RULE_03: Unprotected write data bytes are acknowledged
// RULE_04: Master ends every write with stop
// RULE_05: Page write holds sixteen bytes, one page
// RULE_06: Master avoids page overrun; overrun wraps page
// RULE_07: Page write takes one to sixteen bytes
// RULE_08: Protected page write: no acknowledge, no change
// RULE_09: Page write increments only low four bits
// RULE_10: Write cycle releases bus, commits latched bytes
// RULE_11: Busy device ignores select; ready device acknowledges
// RULE_12: Master polls select until acknowledged
// RULE_13: Random read repeats same seven select bits
// RULE_14: Reads ignore the protect input
// RULE_15: Random read: dummy write, restart, read
// RULE_16: Master ends single read with no acknowledge
// RULE_17: Current read returns counter byte, then increments
// RULE_18: Acknowledged read byte continues with next byte
// RULE_19: Read counter walks whole array, wraps zero
// RULE_20: Missing master acknowledge returns to standby
// RULE_21: Array starts with every byte erased
// RULE_22: Only stop right after acknowledge starts write
// RULE_23: Protection covers upper half while input high
// RULE_24: Respond only to matching type and chip select
// RULE_25: Write cycle is a bounded counter, bus ignored
package sep_pkg;
    localparam int          CLK_PERIOD_NS          = 5;
    localparam int          INTERNAL_WRITE_TIME_NS = 5000000;
    // Longest time, so the division rounds down
    localparam int          INTERNAL_WRITE_CYC     = INTERNAL_WRITE_TIME_NS / CLK_PERIOD_NS;
    localparam int          ARRAY_ADDR_W           = 9;
    localparam int          FIFO_DEPTH             = 4;
    localparam int          PROG_CYC               = 4;
    localparam logic [4:0]  PAGE_BYTES             = 5'h10;
    localparam logic [3:0]  BIT_CNT_BYTE           = 4'h8;
    localparam logic [8:0]  PROTECT_LO             = 9'h100;
    localparam logic [8:0]  ADDR_RESET             = 9'h000;
    localparam logic [7:0]  ERASED_BYTE            = 8'hFF;

    typedef enum {
        ST_IDLE, ST_DEVSEL, ST_ADDR, ST_WDATA, ST_ACK, ST_RDATA, ST_RACK, ST_BUSY
    } sep_state_t;

    typedef struct packed {
        logic [8:0] addr;
        logic [7:0] data;
    } sep_wr_t;
endpackage : sep_pkg

// ==== verilog/sep_fifo.sv ====
`timescale 1ns/1ps
module sep_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 4
) (
    input  wire logic             core_clk,
    input  wire logic             arst_n,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] slot_ff [DEPTH];
    logic [PW-1:0]    wrPtr_ff, nxt_wrPtr, rdPtr_ff, nxt_rdPtr;
    logic [PW:0]      count_ff, nxt_count;
    logic             push, pop;

    ////////////////////////////////////////////////////////////////////////////
    // Full and empty come from the count, so both sides see honest flags
    assign inReady  = (count_ff < (PW+1)'(DEPTH));
    assign outValid = (count_ff != '0);
    assign outData  = slot_ff[rdPtr_ff];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    // Pointers wrap at the depth, which need not be a power of two
    always_comb begin
        nxt_wrPtr = wrPtr_ff;
        nxt_rdPtr = rdPtr_ff;
        nxt_count = count_ff;
        if (push) begin
            nxt_wrPtr = (wrPtr_ff == PW'(DEPTH-1)) ? '0 : wrPtr_ff + 1'b1;
        end
        if (pop) begin
            nxt_rdPtr = (rdPtr_ff == PW'(DEPTH-1)) ? '0 : rdPtr_ff + 1'b1;
        end
        nxt_count = count_ff + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
        end else begin
            wrPtr_ff <= nxt_wrPtr;
            rdPtr_ff <= nxt_rdPtr;
            count_ff <= nxt_count;
        end
    end

    // Storage holds no reset; only the count decides what is valid
    always_ff @(posedge core_clk) begin
        if (push) begin
            slot_ff[wrPtr_ff] <= inData;
        end
    end
endmodule : sep_fifo

// ==== verilog/sep_mem.sv ====
`timescale 1ns/1ps
module sep_mem #(
    parameter int ADDR_W   = 9,
    parameter int DATA_W   = 8,
    parameter int PROG_CYC = 4
) (
    input  wire logic              core_clk,
    input  wire logic              arst_n,
    input  wire logic              rdEn,
    input  wire logic [ADDR_W-1:0] rdAddr,
    output logic      [DATA_W-1:0] rdData,
    input  wire logic              wrValid,
    output logic                   wrReady,
    input  wire logic [ADDR_W-1:0] wrAddr,
    input  wire logic [DATA_W-1:0] wrData
);
    logic [DATA_W-1:0] cells [2**ADDR_W];
    logic [DATA_W-1:0] rdData_ff;
    logic [7:0]        progCnt_ff, nxt_progCnt;

    ////////////////////////////////////////////////////////////////////////////
    // Erased array at start of life
    initial begin
        for (int i = 0; i < 2**ADDR_W; i++) begin
            cells[i] = sep_pkg::ERASED_BYTE; // [RULE_21]
        end
    end

    // Each byte programs for a few cycles; this is what back-pressures the FIFO
    assign wrReady = (progCnt_ff == 8'h00);
    assign rdData  = rdData_ff;

    always_comb begin
        nxt_progCnt = progCnt_ff;
        if (wrValid && wrReady) begin
            nxt_progCnt = 8'(PROG_CYC);
        end else if (progCnt_ff != 8'h00) begin
            nxt_progCnt = progCnt_ff - 8'h01;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            progCnt_ff <= 8'h00;
        end else begin
            progCnt_ff <= nxt_progCnt;
        end
    end

    // Array and read register carry no reset, like real cells
    always_ff @(posedge core_clk) begin
        if (wrValid && wrReady) begin
            cells[wrAddr] <= wrData; // [RULE_10]
        end
        if (rdEn) begin
            rdData_ff <= cells[rdAddr];
        end
    end

    a_prog_pace: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE_10]
        wrValid && wrReady |=> !wrReady)
        else $error("memory took a second byte while programming");
endmodule : sep_mem

// ==== verilog/sep_eeprom.sv ====
`timescale 1ns/1ps
module sep_eeprom #(
    parameter int unsigned WriteCycles = sep_pkg::INTERNAL_WRITE_CYC,
    parameter logic [3:0]  DeviceType  = 4'h6 // Arbitrary value
) (
    input  wire logic core_clk,
    input  wire logic arst_n,
    input  wire logic sclPin,
    input  wire logic sdaIn,
    output logic      sdaOut,
    output logic      sdaOe,
    input  wire logic writeProtectInput,
    input  wire logic chipSelectPinLo,
    input  wire logic chipSelectPinHi,
    output logic      writeBusy
);
    // Page latch size and the width of one queued array write
    localparam int         PAGE_N    = int'(sep_pkg::PAGE_BYTES);
    localparam int         WR_W      = $bits(sep_pkg::sep_wr_t);
    // Bus lines idle high, so they reset high and no false edge follows reset
    localparam logic [4:0] SYNC_IDLE = 5'h03;

    ////////////////////////////////////////////////////////////////////////////
    // State and wiring
    logic [4:0]          syncA_ff, nxt_syncA;
    logic [4:0]          syncB_ff, nxt_syncB;
    logic                sclPrev_ff, nxt_sclPrev;
    logic                sdaPrev_ff, nxt_sdaPrev;
    logic                sclS, sdaS, wpS, csLoS, csHiS;
    logic                sclRise, sclFall, startSeen, stopSeen;
    sep_pkg::sep_state_t state_ff, nxt_state;
    sep_pkg::sep_state_t retSt_ff, nxt_retSt;
    logic [3:0]          bitCnt_ff, nxt_bitCnt;
    logic [7:0]          rxShift_ff, nxt_rxShift;
    logic [7:0]          txShift_ff, nxt_txShift;
    logic [8:0]          addrCnt_ff, nxt_addrCnt;
    logic                addrMsb_ff, nxt_addrMsb;
    logic                wpSeen_ff, nxt_wpSeen;
    logic                protHit_ff, nxt_protHit;
    logic                mAck_ff, nxt_mAck;
    logic                sdaOut_ff, nxt_sdaOut;
    logic                sdaOe_ff, nxt_sdaOe;
    logic                writeBusy_ff, nxt_writeBusy;
    logic [31:0]         busyCnt_ff, nxt_busyCnt;
    logic [7:0]          pageData_ff [PAGE_N];
    logic [7:0]          nxt_pageData [PAGE_N];
    logic [PAGE_N-1:0]   pageValid_ff, nxt_pageValid;
    logic [4:0]          pageBase_ff, nxt_pageBase;
    logic [3:0]          drainIdx_ff, nxt_drainIdx;
    logic                drainDone_ff, nxt_drainDone;
    logic                selMatch, byteDone, rxPhase;
    logic [8:0]          fullAddr;
    logic                memRdEn, memWrReady;
    logic [7:0]          memRdData;
    logic                fifoPush, fifoInReady, fifoOutValid;
    sep_pkg::sep_wr_t    fifoIn, fifoOut;
    logic [WR_W-1:0]     fifoOutBits;

    ////////////////////////////////////////////////////////////////////////////
    // Two-stage synchronisers on every pin, then one more stage for edges
    always_comb begin
        nxt_syncA   = {chipSelectPinHi, chipSelectPinLo, writeProtectInput, sdaIn, sclPin};
        nxt_syncB   = syncA_ff;
        nxt_sclPrev = syncB_ff[0];
        nxt_sdaPrev = syncB_ff[1];
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            syncA_ff   <= SYNC_IDLE;
            syncB_ff   <= SYNC_IDLE;
            sclPrev_ff <= 1'b1;
            sdaPrev_ff <= 1'b1;
        end else begin
            syncA_ff   <= nxt_syncA;
            syncB_ff   <= nxt_syncB;
            sclPrev_ff <= nxt_sclPrev;
            sdaPrev_ff <= nxt_sdaPrev;
        end
    end

    assign sclS      = syncB_ff[0];
    assign sdaS      = syncB_ff[1];
    assign wpS       = syncB_ff[2];
    assign csLoS     = syncB_ff[3];
    assign csHiS     = syncB_ff[4];
    assign sclRise   = sclS && !sclPrev_ff;
    assign sclFall   = !sclS && sclPrev_ff;
    // Data edges while the clock stands high are frame marks
    assign startSeen = sclS && sclPrev_ff && sdaPrev_ff && !sdaS;
    assign stopSeen  = sclS && sclPrev_ff && !sdaPrev_ff && sdaS;

    // Byte decode helpers; a byte is complete at the fall after its eighth rise
    assign byteDone  = sclFall && (bitCnt_ff == sep_pkg::BIT_CNT_BYTE);
    assign selMatch  = (rxShift_ff[7:4] == DeviceType) && (rxShift_ff[3] == csHiS)
                       && (rxShift_ff[2] == csLoS); // [RULE_24]
    assign fullAddr  = {addrMsb_ff, rxShift_ff};
    assign rxPhase   = (state_ff == sep_pkg::ST_DEVSEL) || (state_ff == sep_pkg::ST_ADDR)
                       || (state_ff == sep_pkg::ST_WDATA);
    assign memRdEn   = (state_ff == sep_pkg::ST_ACK) || (state_ff == sep_pkg::ST_RACK);
    assign fifoIn    = '{addr: {pageBase_ff, drainIdx_ff}, data: pageData_ff[drainIdx_ff]};
    assign fifoOut   = fifoOutBits;

    ////////////////////////////////////////////////////////////////////////////
    // Command engine: next values
    always_comb begin
        nxt_state     = state_ff;
        nxt_retSt     = retSt_ff;
        nxt_bitCnt    = bitCnt_ff;
        nxt_rxShift   = rxShift_ff;
        nxt_txShift   = txShift_ff;
        nxt_addrCnt   = addrCnt_ff;
        nxt_addrMsb   = addrMsb_ff;
        nxt_wpSeen    = wpSeen_ff;
        nxt_protHit   = protHit_ff;
        nxt_mAck      = mAck_ff;
        nxt_sdaOut    = sdaOut_ff;
        nxt_sdaOe     = sdaOe_ff;
        nxt_busyCnt   = busyCnt_ff;
        nxt_pageData  = pageData_ff;
        nxt_pageValid = pageValid_ff;
        nxt_pageBase  = pageBase_ff;
        nxt_drainIdx  = drainIdx_ff;
        nxt_drainDone = drainDone_ff;
        fifoPush      = 1'b0;
        // Receiving states sample data on each clock rise
        if (rxPhase && sclRise) begin
            nxt_rxShift = {rxShift_ff[6:0], sdaS};
            nxt_bitCnt  = bitCnt_ff + 4'h1;
        end
        case (state_ff)
            sep_pkg::ST_IDLE: begin
                nxt_sdaOe = 1'b0;
            end
            sep_pkg::ST_DEVSEL: begin
                nxt_wpSeen = wpSeen_ff || wpS; // [RULE_02]
                if (byteDone) begin
                    nxt_bitCnt = 4'h0;
                    if (!selMatch) begin
                        nxt_state = sep_pkg::ST_IDLE; // [RULE_24]
                    end else begin
                        nxt_state  = sep_pkg::ST_ACK;
                        nxt_sdaOe  = 1'b1;
                        nxt_sdaOut = 1'b0;
                        if (rxShift_ff[0]) begin
                            // Reads ignore the protect input [RULE_14] [RULE_15]
                            nxt_retSt = sep_pkg::ST_RDATA;
                        end else begin
                            nxt_retSt   = sep_pkg::ST_ADDR;
                            nxt_addrMsb = rxShift_ff[1]; // [RULE_24]
                        end
                    end
                end
            end
            sep_pkg::ST_ADDR: begin
                nxt_wpSeen = wpSeen_ff || wpS; // [RULE_08]
                if (byteDone) begin
                    nxt_bitCnt    = 4'h0;
                    nxt_addrCnt   = fullAddr; // [RULE_15]
                    nxt_pageBase  = fullAddr[8:4]; // [RULE_05]
                    nxt_pageValid = '0;
                    nxt_protHit   = (wpSeen_ff || wpS) && (fullAddr >= sep_pkg::PROTECT_LO); // [RULE_23]
                    nxt_state     = sep_pkg::ST_ACK;
                    nxt_retSt     = sep_pkg::ST_WDATA;
                    nxt_sdaOe     = 1'b1;
                    nxt_sdaOut    = 1'b0;
                end
            end
            sep_pkg::ST_WDATA: begin
                if (byteDone) begin
                    nxt_bitCnt = 4'h0;
                    if (protHit_ff) begin
                        // Withheld ack; nothing latched, so nothing is written [RULE_02] [RULE_08]
                        nxt_state = sep_pkg::ST_IDLE;
                    end else begin
                        nxt_pageData[addrCnt_ff[3:0]]  = rxShift_ff; // [RULE_05] [RULE_07]
                        nxt_pageValid[addrCnt_ff[3:0]] = 1'b1;
                        // Only the low nibble moves, so an overrun wraps in the page
                        nxt_addrCnt = {addrCnt_ff[8:4], addrCnt_ff[3:0] + 4'h1}; // [RULE_09]
                        nxt_state   = sep_pkg::ST_ACK; // [RULE_01] [RULE_03]
                        nxt_retSt   = sep_pkg::ST_WDATA;
                        nxt_sdaOe   = 1'b1;
                        nxt_sdaOut  = 1'b0;
                    end
                end
            end
            sep_pkg::ST_ACK: begin
                if (sclFall) begin
                    nxt_state  = retSt_ff;
                    nxt_bitCnt = 4'h0;
                    if (retSt_ff == sep_pkg::ST_RDATA) begin
                        // First data bit leaves on the fall that ends the ack
                        nxt_sdaOut  = memRdData[7];
                        nxt_txShift = {memRdData[6:0], 1'b0};
                        nxt_bitCnt  = 4'h1;
                        nxt_addrCnt = addrCnt_ff + 9'h001; // [RULE_17] [RULE_19]
                    end else begin
                        nxt_sdaOe = 1'b0;
                    end
                end
            end
            sep_pkg::ST_RDATA: begin
                if (sclFall) begin
                    if (bitCnt_ff == sep_pkg::BIT_CNT_BYTE) begin
                        nxt_sdaOe  = 1'b0; // Master owns the ninth bit
                        nxt_bitCnt = 4'h0;
                        nxt_state  = sep_pkg::ST_RACK;
                    end else begin
                        nxt_sdaOut  = txShift_ff[7];
                        nxt_txShift = {txShift_ff[6:0], 1'b0};
                        nxt_bitCnt  = bitCnt_ff + 4'h1;
                    end
                end
            end
            sep_pkg::ST_RACK: begin
                if (sclRise) begin
                    nxt_mAck = !sdaS; // [RULE_20]
                end
                if (sclFall) begin
                    if (mAck_ff) begin
                        nxt_state   = sep_pkg::ST_RDATA; // [RULE_18]
                        nxt_sdaOe   = 1'b1;
                        nxt_sdaOut  = memRdData[7];
                        nxt_txShift = {memRdData[6:0], 1'b0};
                        nxt_bitCnt  = 4'h1;
                        nxt_addrCnt = addrCnt_ff + 9'h001; // [RULE_19]
                    end else begin
                        nxt_state = sep_pkg::ST_IDLE; // [RULE_20]
                    end
                end
            end
            sep_pkg::ST_BUSY: begin
                // Bus is ignored here; the latch drains into the array [RULE_10] [RULE_11]
                if (busyCnt_ff != 32'h0) begin
                    nxt_busyCnt = busyCnt_ff - 32'h1; // [RULE_25]
                end
                if (!drainDone_ff) begin
                    fifoPush = pageValid_ff[drainIdx_ff];
                    if (!pageValid_ff[drainIdx_ff] || fifoInReady) begin
                        nxt_pageValid[drainIdx_ff] = 1'b0;
                        nxt_drainIdx               = drainIdx_ff + 4'h1;
                        nxt_drainDone              = (drainIdx_ff == 4'hF);
                    end
                end
                // Leave only once time is up and every byte has programmed
                if ((busyCnt_ff == 32'h0) && drainDone_ff && !fifoOutValid && memWrReady) begin
                    nxt_state = sep_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_state = sep_pkg::ST_IDLE;
            end
        endcase
        // Frame marks win over the bit engine, except during the write cycle
        if (state_ff != sep_pkg::ST_BUSY) begin
            if (startSeen) begin
                nxt_state  = sep_pkg::ST_DEVSEL;
                nxt_bitCnt = 4'h0;
                nxt_sdaOe  = 1'b0;
                nxt_wpSeen = wpS; // [RULE_02]
            end else if (stopSeen) begin
                nxt_bitCnt = 4'h0;
                nxt_sdaOe  = 1'b0;
                nxt_state  = sep_pkg::ST_IDLE;
                // The stop's own clock rise counts one bit after the ack slot
                if ((state_ff == sep_pkg::ST_WDATA) && (bitCnt_ff == 4'h1) && (|pageValid_ff)) begin
                    nxt_state     = sep_pkg::ST_BUSY; // [RULE_22]
                    nxt_busyCnt   = 32'(WriteCycles); // [RULE_25]
                    nxt_drainIdx  = 4'h0;
                    nxt_drainDone = 1'b0;
                end
            end
        end
        nxt_writeBusy = (nxt_state == sep_pkg::ST_BUSY);
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff     <= sep_pkg::ST_IDLE;
            retSt_ff     <= sep_pkg::ST_IDLE;
            bitCnt_ff    <= 4'h0;
            rxShift_ff   <= 8'h00;
            txShift_ff   <= 8'h00;
            addrCnt_ff   <= sep_pkg::ADDR_RESET;
            addrMsb_ff   <= 1'b0;
            wpSeen_ff    <= 1'b0;
            protHit_ff   <= 1'b0;
            mAck_ff      <= 1'b0;
            sdaOut_ff    <= 1'b0;
            sdaOe_ff     <= 1'b0;
            writeBusy_ff <= 1'b0;
            busyCnt_ff   <= 32'h0;
            pageValid_ff <= '0;
            pageBase_ff  <= 5'h00;
            drainIdx_ff  <= 4'h0;
            drainDone_ff <= 1'b1;
        end else begin
            state_ff     <= nxt_state;
            retSt_ff     <= nxt_retSt;
            bitCnt_ff    <= nxt_bitCnt;
            rxShift_ff   <= nxt_rxShift;
            txShift_ff   <= nxt_txShift;
            addrCnt_ff   <= nxt_addrCnt;
            addrMsb_ff   <= nxt_addrMsb;
            wpSeen_ff    <= nxt_wpSeen;
            protHit_ff   <= nxt_protHit;
            mAck_ff      <= nxt_mAck;
            sdaOut_ff    <= nxt_sdaOut;
            sdaOe_ff     <= nxt_sdaOe;
            writeBusy_ff <= nxt_writeBusy;
            busyCnt_ff   <= nxt_busyCnt;
            pageValid_ff <= nxt_pageValid;
            pageBase_ff  <= nxt_pageBase;
            drainIdx_ff  <= nxt_drainIdx;
            drainDone_ff <= nxt_drainDone;
        end
    end

    // Page latch data needs no reset; the valid mask guards it
    always_ff @(posedge core_clk) begin
        pageData_ff <= nxt_pageData;
    end

    assign sdaOut    = sdaOut_ff;
    assign sdaOe     = sdaOe_ff;
    assign writeBusy = writeBusy_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Write queue and array; the queue absorbs the array's programming pace
    sep_fifo #(
        .WIDTH (WR_W),
        .DEPTH (sep_pkg::FIFO_DEPTH)
    ) u_fifo (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .inValid  (fifoPush),
        .inReady  (fifoInReady),
        .inData   (fifoIn),
        .outValid (fifoOutValid),
        .outReady (memWrReady),
        .outData  (fifoOutBits)
    );

    sep_mem #(
        .ADDR_W   (sep_pkg::ARRAY_ADDR_W),
        .DATA_W   (8),
        .PROG_CYC (sep_pkg::PROG_CYC)
    ) u_mem (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .rdEn     (memRdEn),
        .rdAddr   (addrCnt_ff),
        .rdData   (memRdData),
        .wrValid  (fifoOutValid),
        .wrReady  (memWrReady),
        .wrAddr   (fifoOut.addr),
        .wrData   (fifoOut.data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the engine
    a_busy_quiet: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE_11]
        writeBusy_ff |-> !sdaOe_ff)
        else $error("data line driven during the write cycle");
    a_protect_nack: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE_02]
        (state_ff == sep_pkg::ST_WDATA) && protHit_ff && byteDone
        |=> !sdaOe_ff && (state_ff == sep_pkg::ST_IDLE))
        else $error("protected data byte was acknowledged");
    a_page_upper: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE_09]
        (state_ff == sep_pkg::ST_WDATA) && byteDone
        |=> addrCnt_ff[8:4] == $past(addrCnt_ff[8:4]))
        else $error("page write moved the upper address bits");
    a_write_trigger: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE_22]
        !writeBusy_ff ##1 writeBusy_ff
        |-> ($past(state_ff) == sep_pkg::ST_WDATA) && ($past(bitCnt_ff) == 4'h1))
        else $error("write cycle began away from the ack slot");
    a_busy_bounded: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE_25]
        busyCnt_ff <= WriteCycles)
        else $error("write timer beyond its bound");
    a_read_nack: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE_20]
        (state_ff == sep_pkg::ST_RACK) && sclFall && !mAck_ff
        |=> (state_ff == sep_pkg::ST_IDLE) && !sdaOe_ff)
        else $error("read went on without a master ack");
    a_select_nack: assert property (@(posedge core_clk) disable iff (!arst_n) // [RULE_24]
        (state_ff == sep_pkg::ST_DEVSEL) && byteDone && !selMatch |=> !sdaOe_ff)
        else $error("foreign select byte was acknowledged");
endmodule : sep_eeprom

// ==== bench/sep_master.sv ====
`timescale 1ns/1ps
// Open-drain bus master; its clock stands high between frames
module sep_master (
    input  wire logic core_clk,
    input  wire logic sdaBus,
    output logic      sclPin,
    output logic      sdaLow
);
    initial begin
        sclPin = 1'b1;
        sdaLow = 1'b0;
    end
    // 16 core cycles make the 80 ns half period
    task automatic hp();
        repeat (16) @(negedge core_clk);
    endtask : hp
    // Data moves a little after clock low, never with it
    task automatic bitx(input logic b, output logic q);
        repeat (4) @(negedge core_clk);
        sdaLow = !b;
        hp();
        sclPin = 1'b1;
        hp();
        q = sdaBus;
        sclPin = 1'b0;
    endtask : bitx
    // Also serves as the repeated start
    task automatic start();
        sdaLow = 1'b0;
        hp();
        sclPin = 1'b1;
        hp();
        sdaLow = 1'b1;
        hp();
        sclPin = 1'b0;
    endtask : start
    task automatic stop();
        repeat (4) @(negedge core_clk);
        sdaLow = 1'b1;
        hp();
        sclPin = 1'b1;
        hp();
        sdaLow = 1'b0;
        hp();
    endtask : stop
    task automatic xfer(input logic [7:0] v, input logic a, output logic [7:0] d, output logic q);
        for (int i = 7; i >= 0; i--) bitx(v[i], d[i]);
        bitx(a, q);
    endtask : xfer
endmodule : sep_master

// ==== bench/serial_eeprom_write_read_ops_test.sv ====
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
    $display("[FAIL] %0t %h %h", $time, (a), (e)); end end
module serial_eeprom_write_read_ops_test;
    logic       coreClk, arstN, wp, scl, mLow, sdaOut, sdaOe, busy, r;
    logic [7:0] d;
    int         bad_count, num_checks;
    // Pull-up on the data line
    wire        sda = mLow ? 1'b0 : (sdaOe ? sdaOut : 1'b1);
    sep_eeprom #(.WriteCycles(2000)) dut (.core_clk(coreClk), .arst_n(arstN), .sclPin(scl),
        .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .writeProtectInput(wp),
        .chipSelectPinLo(1'b1), .chipSelectPinHi(1'b0), .writeBusy(busy));
    sep_master m (.core_clk(coreClk), .sdaBus(sda), .sclPin(scl), .sdaLow(mLow));
    function automatic logic [7:0] sel(input logic a8, input logic rw);
        return {4'h6, 1'b0, 1'b1, a8, rw};
    endfunction : sel
    task automatic addr(input logic [8:0] a);
        m.start();
        m.xfer(sel(a[8], 1'b0), 1'b1, d, r);
        m.xfer(a[7:0], 1'b1, d, r);
    endtask : addr
    // Poll is bounded so a stuck device cannot hang the run
    task automatic wr(input logic [8:0] a, input logic [7:0] v, input int n, input logic ea);
        addr(a);
        for (int k = 0; k < n; k++) begin
            m.xfer(v + 8'(k), 1'b1, d, r);
            `CHK(r, ea)
        end
        m.stop();
        if (!ea) `CHK(busy, 1'b1)
        for (int i = 0; i < 50; i++) begin
            m.start();
            m.xfer(sel(1'b0, 1'b0), 1'b1, d, r);
            m.stop();
            if (i == 0 && !ea) `CHK(r, 1'b1)
            if (r === 1'b0) return;
        end
        bad_count++;
    endtask : wr
    task automatic rd(input logic [8:0] a, input logic [7:0] e0, e1);
        addr(a);
        m.start();
        m.xfer(sel(a[8], 1'b1), 1'b1, d, r);
        `CHK(r, 1'b0)
        m.xfer(8'hFF, 1'b0, d, r);
        `CHK(d, e0)
        m.xfer(8'hFF, 1'b1, d, r);
        `CHK(d, e1)
        m.stop();
    endtask : rd
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    initial begin
        coreClk = 1'b0;
        forever #2.5 coreClk = ~coreClk;
    end
    initial begin
        #400us;
        bad_count++;
        finish_test();
    end
    initial begin
        arstN = 1'b0;
        wp = 1'b0;
        repeat (4) @(negedge coreClk);
        arstN = 1'b1;
        rd(9'h000, 8'hFF, 8'hFF);
        wr(9'h000, 8'h3C, 1, 1'b0);
        rd(9'h000, 8'h3C, 8'hFF);
        wp = 1'b1;
        wr(9'h105, 8'h5A, 1, 1'b1);
        wr(9'h0A0, 8'h11, 2, 1'b0);
        rd(9'h105, 8'hFF, 8'hFF);
        wp = 1'b0;
        wr(9'h1FE, 8'h70, 3, 1'b0);
        rd(9'h1F0, 8'h72, 8'hFF);
        rd(9'h1FE, 8'h70, 8'h71);
        m.start();
        m.xfer(sel(1'b0, 1'b1), 1'b1, d, r);
        m.xfer(8'hFF, 1'b1, d, r);
        `CHK(d, 8'h3C)
        m.stop();
        m.start();
        m.xfer({4'h6, 2'b10, 2'b00}, 1'b1, d, r);
        `CHK(r, 1'b1)
        m.stop();
        finish_test();
    end
endmodule : serial_eeprom_write_read_ops_test
